// File: common/tuner_regs_pkg.sv
package tuner_regs_pkg;

  localparam int NUM_PROG = 11;
  localparam logic [7:0] NUM_PROG_BYTE = 8'h0B;

  localparam logic [3:0] OFS_INT_DIV_HIGH = 4'h0;
  localparam logic [3:0] OFS_INT_DIV_LOW = 4'h1;
  localparam logic [3:0] OFS_REF_DIV = 4'h2;
  localparam logic [3:0] OFS_OSC_BAND = 4'h3;
  localparam logic [3:0] OFS_DET_PUMP_FILTER = 4'h4;
  localparam logic [3:0] OFS_CONTROL = 4'h5;
  localparam logic [3:0] OFS_SHUTDOWN = 4'h6;
  localparam logic [3:0] OFS_SERIES_CAP = 4'h7;
  localparam logic [3:0] OFS_PARALLEL_CAP = 4'h8;
  localparam logic [3:0] OFS_ROM_ADDRESS = 4'h9;
  localparam logic [3:0] OFS_RESERVED_SLOT = 4'hA;
  localparam logic [3:0] OFS_ROM_READBACK = 4'hB;
  localparam logic [3:0] OFS_STATUS = 4'hC;

  // Writable bits of each programmable register; the rest always read zero.
  localparam logic [7:0] MASK_HIGH7 = 8'h7F;
  localparam logic [7:0] MASK_LOW4 = 8'h0F;
  localparam logic [7:0] MASK_SHUTDOWN = 8'hF8;
  localparam logic [7:0] MASK_PARALLEL = 8'hBF;
  localparam logic [7:0] MASK_FULL = 8'hFF;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [3:0] STATUS_LOW_ZERO = 4'h0;
  localparam logic POR_RESET = 1'b1;

  // Field positions.
  localparam int LOAD_BIT = 7;
  localparam int PAR_CAP_MSB = 5;
  localparam int ROM_ADDR_MSB = 3;
  localparam int INT_HIGH_MSB = 6;
  localparam int REF_DIV_MSB = 6;
  localparam int OVLD_MSB = 6;
  localparam int OVLD_LSB = 4;
  localparam int PUMP_MSB = 3;
  localparam int PUMP_LSB = 2;
  localparam int BAND_MSB = 1;
  localparam int RF_DOWN_BIT = 3;
  localparam int IF_GAIN_DOWN_BIT = 2;
  localparam int INPUT_MSB = 1;
  localparam int MIX_MSB = 7;
  localparam int MIX_LSB = 6;
  localparam int IF_DOWN_BIT = 5;
  localparam int DET_DOWN_BIT = 4;
  localparam int SYN_DOWN_BIT = 3;

  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [4:0] ADDR_UPPER_DEFAULT = 5'h18;
  localparam logic [127:0] ROM_TABLE_DEFAULT = 128'h0;

  function automatic logic [7:0] writeMask(input logic [3:0] idx);
    unique case (idx)
      OFS_INT_DIV_HIGH, OFS_REF_DIV, OFS_DET_PUMP_FILTER: writeMask = MASK_HIGH7;
      OFS_CONTROL, OFS_ROM_ADDRESS: writeMask = MASK_LOW4;
      OFS_SHUTDOWN: writeMask = MASK_SHUTDOWN;
      OFS_PARALLEL_CAP: writeMask = MASK_PARALLEL;
      default: writeMask = MASK_FULL;
    endcase
  endfunction

endpackage

// File: hw/filter_rom.sv
`timescale 1ns/100ps
`default_nettype none
module filter_rom
  import tuner_regs_pkg::*;
#(
  parameter logic [127:0] TABLE = ROM_TABLE_DEFAULT
) (
  input wire logic [3:0] index,
  output logic [7:0] data
);

  // Sixteen table bytes, entry 0 in the low byte; contents are calibration data.
  assign data = TABLE[{index, 3'b000} +: 8];

endmodule
`default_nettype wire

// File: hw/i2c_target_port.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_target_port
  import tuner_regs_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic [6:0] ownAddr,
  input wire logic [7:0] txData,
  output logic sdaOe,
  output logic rxValid,
  output logic [7:0] rxData,
  output logic rxFirst,
  output logic txLoad
);

  typedef enum logic [2:0] {
    IDLE, ADDR, ACK_ADDR, WRITE, ACK_WRITE, READ, ACK_READ
  } phase_type;

  typedef struct packed {
    phase_type phase;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic rw;
    logic first;
    logic masterAck;
    logic sclPrev;
    logic sdaPrev;
    logic sdaOe;
    logic rxValid;
    logic txLoad;
  } port_type;

  port_type r, nxt;
  logic sclRise, sclFall, startCond, stopCond;

  assign sclRise = sclIn & ~r.sclPrev;
  assign sclFall = ~sclIn & r.sclPrev;
  assign startCond = sclIn & r.sclPrev & r.sdaPrev & ~sdaIn;
  assign stopCond = sclIn & r.sclPrev & ~r.sdaPrev & sdaIn;

  always_comb begin
    nxt = r;
    nxt.sclPrev = sclIn;
    nxt.sdaPrev = sdaIn;
    nxt.rxValid = 1'b0;
    nxt.txLoad = 1'b0;
    if (startCond) begin
      // A repeated start keeps the register pointer in the bank.
      nxt.phase = ADDR;
      nxt.bitCnt = '0;
      nxt.sdaOe = 1'b0;
      nxt.first = 1'b1;
    end else if (stopCond) begin
      nxt.phase = IDLE;
      nxt.sdaOe = 1'b0;
    end else begin
      unique case (r.phase)
        IDLE: begin
        end
        ADDR, WRITE: begin
          if (sclRise) begin
            nxt.shift = {r.shift[6:0], sdaIn};
            nxt.bitCnt = r.bitCnt + 4'h1;
          end else if (sclFall && r.bitCnt == BYTE_BITS) begin
            nxt.bitCnt = '0;
            if (r.phase == WRITE) begin
              nxt.rxValid = 1'b1;
              nxt.sdaOe = 1'b1;
              nxt.phase = ACK_WRITE;
            end else if (r.shift[7:1] == ownAddr) begin // [R08]
              nxt.rw = r.shift[0];
              nxt.sdaOe = 1'b1;
              nxt.phase = ACK_ADDR;
            end else begin
              nxt.phase = IDLE;
            end
          end
        end
        ACK_ADDR: begin
          if (sclFall) begin
            nxt.bitCnt = '0;
            if (r.rw) begin
              nxt.shift = txData;
              nxt.sdaOe = ~txData[7];
              nxt.txLoad = 1'b1;
              nxt.phase = READ;
            end else begin
              nxt.sdaOe = 1'b0;
              nxt.phase = WRITE;
            end
          end
        end
        ACK_WRITE: begin
          if (sclFall) begin
            nxt.sdaOe = 1'b0;
            nxt.first = 1'b0;
            nxt.phase = WRITE;
          end
        end
        READ: begin
          if (sclRise) begin
            nxt.bitCnt = r.bitCnt + 4'h1;
          end else if (sclFall) begin
            if (r.bitCnt == BYTE_BITS) begin
              nxt.sdaOe = 1'b0;
              nxt.phase = ACK_READ;
            end else begin
              nxt.shift = {r.shift[6:0], 1'b0};
              nxt.sdaOe = ~r.shift[6];
            end
          end
        end
        ACK_READ: begin
          if (sclRise) begin
            nxt.masterAck = ~sdaIn;
          end else if (sclFall) begin
            nxt.bitCnt = '0;
            if (r.masterAck) begin
              nxt.shift = txData;
              nxt.sdaOe = ~txData[7];
              nxt.txLoad = 1'b1;
              nxt.phase = READ;
            end else begin
              // A not-acknowledge ends the read; the line is left released.
              nxt.phase = IDLE;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '{phase: IDLE, bitCnt: '0, shift: '0, rw: 1'b0, first: 1'b0,
             masterAck: 1'b0, sclPrev: 1'b1, sdaPrev: 1'b1, sdaOe: 1'b0,
             rxValid: 1'b0, txLoad: 1'b0};
    end else begin
      r <= nxt;
    end
  end

  assign sdaOe = r.sdaOe;
  assign rxValid = r.rxValid;
  assign rxData = r.shift;
  assign rxFirst = r.first;
  assign txLoad = r.txLoad;

endmodule
`default_nettype wire

// File: hw/tuner_control_register_bank.sv
// Summary of operation
// [R01] Host programs all registers 100 us after power.
// [R02] Host must not trust power-up register values.
// [R03] Programmable registers read back last written value.
// [R04] Readback and status registers ignore writes.
// [R05] Divider high register: seven bits, top zero.
// [R06] Host keeps integer divider within 256..32767.
// [R07] Host should load divider 4688 by default.
// [R08] Slave address comes from two select pins.
// [R09] Shutdown register field layout, low bits zero.
// [R10] Control register field layout, high bits zero.
// [R11] Detector, pump, band register layout, bit7 zero.
// [R12] Load bit rising edge loads ROM readback.
// [R13] First write byte sets pointer; data follows.
`timescale 1ns/100ps
`default_nettype none
module tuner_control_register_bank
  import tuner_regs_pkg::*;
#(
  parameter logic [4:0] ADDR_UPPER = ADDR_UPPER_DEFAULT,
  parameter logic [127:0] ROM_TABLE = ROM_TABLE_DEFAULT
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic addrSelectPinA,
  input wire logic addrSelectPinB,
  input wire logic [2:0] lockIndicator,
  output logic [14:0] intDivider,
  output logic [6:0] referenceDivider,
  output logic [7:0] oscBandSelect,
  output logic [2:0] overloadThresholdField,
  output logic [1:0] pumpCurrentSelect,
  output logic [1:0] filterBandSelect,
  output logic rfPowerDown,
  output logic ifGainStagePowerDown,
  output logic [1:0] rfInputSelect,
  output logic [1:0] mixerPowerDown,
  output logic ifSectionPowerDown,
  output logic detectorPowerDown,
  output logic synthPowerDown,
  output logic [7:0] seriesCapSelect,
  output logic [5:0] parallelCapSelect,
  output logic filterTableLoad,
  output logic [3:0] filterRomAddress,
  output logic [7:0] romReadbackBits
);

  typedef struct packed {
    logic [NUM_PROG-1:0][7:0] regs;
    logic [7:0] pointer;
    logic [7:0] romReadback;
    logic porFlag;
  } bank_type;

  bank_type r, nxt;
  logic [6:0] ownAddr;
  logic [7:0] txData;
  logic [7:0] romData;
  logic rxValid, rxFirst, txLoad;
  logic [7:0] rxData;

  // Strapped each cycle so the address follows the pins without a restart.
  assign ownAddr = {ADDR_UPPER, addrSelectPinB, addrSelectPinA}; // [R08]

  i2c_target_port port (
    .clk(clk),
    .nrst(nrst),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .ownAddr(ownAddr),
    .txData(txData),
    .sdaOe(sdaOe),
    .rxValid(rxValid),
    .rxData(rxData),
    .rxFirst(rxFirst),
    .txLoad(txLoad)
  );

  filter_rom #(
    .TABLE(ROM_TABLE)
  ) rom (
    .index(r.regs[OFS_ROM_ADDRESS][ROM_ADDR_MSB:0]),
    .data(romData)
  );

  // The open-drain line is only ever pulled low.
  assign sdaOut = 1'b0;

  always_comb begin
    txData = ZERO_BYTE;
    if (r.pointer < NUM_PROG_BYTE) begin
      txData = r.regs[r.pointer[3:0]]; // [R03]
    end else if (r.pointer == {4'h0, OFS_ROM_READBACK}) begin
      txData = r.romReadback; // [R04]
    end else if (r.pointer == {4'h0, OFS_STATUS}) begin
      txData = {r.porFlag, lockIndicator, STATUS_LOW_ZERO}; // [R04]
    end
  end

  always_comb begin
    logic [3:0] idx;
    logic [7:0] newVal;
    idx = r.pointer[3:0];
    newVal = rxData & writeMask(idx); // [R05] [R09] [R10] [R11]
    nxt = r;
    if (rxValid) begin
      if (rxFirst) begin
        nxt.pointer = rxData; // [R13]
      end else begin
        // Writes beyond the programmable range are acknowledged and dropped.
        if (r.pointer < NUM_PROG_BYTE) begin // [R04]
          nxt.regs[idx] = newVal; // [R03] [R13]
          if (idx == OFS_PARALLEL_CAP && !r.regs[idx][LOAD_BIT] && newVal[LOAD_BIT]) begin
            nxt.romReadback = romData; // [R12]
          end
        end
        nxt.pointer = r.pointer + 8'h01;
      end
    end else if (txLoad) begin
      // Reading status acknowledges the power-on flag.
      if (r.pointer == {4'h0, OFS_STATUS}) begin
        nxt.porFlag = 1'b0;
      end
      nxt.pointer = r.pointer + 8'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '{regs: {NUM_PROG{REG_RESET}}, pointer: ZERO_BYTE,
             romReadback: ZERO_BYTE, porFlag: POR_RESET};
    end else begin
      r <= nxt;
    end
  end

  assign intDivider = {r.regs[OFS_INT_DIV_HIGH][INT_HIGH_MSB:0], r.regs[OFS_INT_DIV_LOW]};
  assign referenceDivider = r.regs[OFS_REF_DIV][REF_DIV_MSB:0];
  assign oscBandSelect = r.regs[OFS_OSC_BAND];
  assign overloadThresholdField = r.regs[OFS_DET_PUMP_FILTER][OVLD_MSB:OVLD_LSB];
  assign pumpCurrentSelect = r.regs[OFS_DET_PUMP_FILTER][PUMP_MSB:PUMP_LSB];
  assign filterBandSelect = r.regs[OFS_DET_PUMP_FILTER][BAND_MSB:0];
  assign rfPowerDown = r.regs[OFS_CONTROL][RF_DOWN_BIT];
  assign ifGainStagePowerDown = r.regs[OFS_CONTROL][IF_GAIN_DOWN_BIT];
  assign rfInputSelect = r.regs[OFS_CONTROL][INPUT_MSB:0];
  assign mixerPowerDown = r.regs[OFS_SHUTDOWN][MIX_MSB:MIX_LSB];
  assign ifSectionPowerDown = r.regs[OFS_SHUTDOWN][IF_DOWN_BIT];
  assign detectorPowerDown = r.regs[OFS_SHUTDOWN][DET_DOWN_BIT];
  assign synthPowerDown = r.regs[OFS_SHUTDOWN][SYN_DOWN_BIT];
  assign seriesCapSelect = r.regs[OFS_SERIES_CAP];
  assign parallelCapSelect = r.regs[OFS_PARALLEL_CAP][PAR_CAP_MSB:0];
  assign filterTableLoad = r.regs[OFS_PARALLEL_CAP][LOAD_BIT];
  assign filterRomAddress = r.regs[OFS_ROM_ADDRESS][ROM_ADDR_MSB:0];
  assign romReadbackBits = r.romReadback;

endmodule
`default_nettype wire

// File: test/tuner_control_register_bank_props.sv
`timescale 1ns/100ps
`default_nettype none
module tuner_control_register_bank_props #(
  parameter logic [127:0] ROM_TABLE = 128'h0
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [14:0] intDivider,
  input wire logic [6:0] referenceDivider,
  input wire logic [2:0] overloadThresholdField,
  input wire logic rfPowerDown,
  input wire logic synthPowerDown,
  input wire logic filterTableLoad,
  input wire logic [3:0] filterRomAddress,
  input wire logic [7:0] romReadbackBits
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  // Outputs may only move in the scl low phase, so the host never sees a glitch mid-bit.
  sequence s_low;
    !sclIn && !$past(sclIn);
  endsequence
  property p_div;
    $changed(intDivider) |-> s_low;
  endproperty
  a_div: assert property (p_div) else $error("divider moved in high phase");
  property p_ref;
    $changed(referenceDivider) |-> s_low;
  endproperty
  a_ref: assert property (p_ref) else $error("ref divider moved in high phase");
  property p_ovl;
    $changed(overloadThresholdField) |-> s_low;
  endproperty
  a_ovl: assert property (p_ovl) else $error("threshold moved in high phase");
  property p_rf;
    $changed(rfPowerDown) |-> s_low;
  endproperty
  a_rf: assert property (p_rf) else $error("rf power down moved in high phase");
  property p_syn;
    $changed(synthPowerDown) |-> s_low;
  endproperty
  a_syn: assert property (p_syn) else $error("synth power down moved in high phase");
  property p_sda;
    $rose(sdaOe) |-> s_low;
  endproperty
  a_sda: assert property (p_sda) else $error("data line pulled in high phase");
  // Any move of the pull, release included, during scl high would read as a start or stop.
  property p_open;
    $changed(sdaOe) |-> (sdaOut == 1'b0) ##0 s_low;
  endproperty
  a_open: assert property (p_open) else $error("data line moved in high phase");
  property p_rom;
    $rose(filterTableLoad) |-> ##[0:2] romReadbackBits == ROM_TABLE[filterRomAddress * 8 +: 8];
  endproperty
  a_rom: assert property (p_rom) else $error("readback not loaded");
endmodule
bind tuner_control_register_bank tuner_control_register_bank_props #(.ROM_TABLE(ROM_TABLE)) props (
  .clk, .nrst, .sclIn, .sdaOut, .sdaOe, .intDivider, .referenceDivider, .overloadThresholdField,
  .rfPowerDown, .synthPowerDown, .filterTableLoad, .filterRomAddress, .romReadbackBits);
`default_nettype wire

// File: test/i2c_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module i2c_host_model (
  input wire logic clk,
  input wire logic devPull,
  output logic scl,
  output logic hostPull
);
  initial begin
    scl = 1'b1;
    hostPull = 1'b0;
  end
  // Four cycles a phase keeps every scl phase above the three-cycle minimum.
  task automatic half();
    repeat (4) @(negedge clk);
  endtask
  task automatic start();
    @(negedge clk);
    hostPull = 1'b0;
    half();
    scl = 1'b1;
    half();
    hostPull = 1'b1;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    @(negedge clk);
    hostPull = 1'b1;
    half();
    scl = 1'b1;
    half();
    hostPull = 1'b0;
    half();
  endtask
  // Data moves a cycle after scl falls so no edge looks like a start or stop.
  task automatic xbyte(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      @(negedge clk);
      hostPull = ~d[i];
      half();
      scl = 1'b1;
      half();
      r[i] = ~(hostPull | devPull);
      scl = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: test/tuner_control_register_bank_tb.sv
`timescale 1ns/100ps
`default_nettype none
module tuner_control_register_bank_tb
  import tuner_regs_pkg::*;
();
  localparam logic [127:0] ROM_TABLE = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0;
  localparam logic [7:0] MASKS [0:10] = '{8'h7F, 8'hFF, 8'h7F, 8'hFF, 8'h7F, 8'h0F, 8'hF8, 8'hFF,
    8'hBF, 8'h0F, 8'hFF};
  logic clk, nrst, sdaOut, sdaOe, addrSelectPinA, addrSelectPinB, scl, hostPull, ackA;
  logic rfPowerDown, ifGainStagePowerDown, ifSectionPowerDown, detectorPowerDown, synthPowerDown;
  logic filterTableLoad;
  logic [14:0] intDivider;
  logic [6:0] referenceDivider, devAddr;
  logic [7:0] oscBandSelect, seriesCapSelect, romReadbackBits;
  logic [2:0] overloadThresholdField, lockIndicator;
  logic [1:0] pumpCurrentSelect, filterBandSelect, rfInputSelect, mixerPowerDown;
  logic [5:0] parallelCapSelect;
  logic [3:0] filterRomAddress;
  logic [8:0] got9;
  logic [7:0] bufW [0:10];
  logic [7:0] bufR [0:10];
  int mismatches = 0, num_checks = 0, cycles = 0;
  wire logic sda;
  assign sda = ~(hostPull | sdaOe);
  tuner_control_register_bank #(.ROM_TABLE(ROM_TABLE)) dut (.clk, .nrst, .sclIn(scl), .sdaIn(sda),
    .sdaOut, .sdaOe, .addrSelectPinA, .addrSelectPinB, .lockIndicator, .intDivider,
    .referenceDivider, .oscBandSelect, .overloadThresholdField, .pumpCurrentSelect,
    .filterBandSelect, .rfPowerDown, .ifGainStagePowerDown, .rfInputSelect, .mixerPowerDown,
    .ifSectionPowerDown, .detectorPowerDown, .synthPowerDown, .seriesCapSelect,
    .parallelCapSelect, .filterTableLoad, .filterRomAddress, .romReadbackBits);
  i2c_host_model host (.clk, .devPull(sdaOe), .scl, .hostPull);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] ptr, input int n);
    host.start();
    host.xbyte({devAddr, 2'h1}, got9);
    ackA = got9[0];
    host.xbyte({ptr, 1'b1}, got9);
    for (int i = 0; i < n; i++) host.xbyte({bufW[i], 1'b1}, got9);
    host.stop();
  endtask
  task automatic rd(input logic [7:0] ptr, input int n);
    host.start();
    host.xbyte({devAddr, 2'h1}, got9);
    host.xbyte({ptr, 1'b1}, got9);
    host.start();
    host.xbyte({devAddr, 2'h3}, got9);
    for (int i = 0; i < n; i++) begin
      host.xbyte({8'hFF, i == n - 1}, got9);
      bufR[i] = got9[8:1];
    end
    host.stop();
  endtask
  task automatic cmpAll();
    for (int i = 0; i < NUM_PROG; i++) chk("readback", {8'h0, bufW[i] & MASKS[i]}, {8'h0, bufR[i]});
  endtask
  initial begin
    nrst = 1'b0;
    addrSelectPinA = 1'b1;
    addrSelectPinB = 1'b0;
    lockIndicator = 3'h5;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (10000) @(negedge clk);
    devAddr = {ADDR_UPPER_DEFAULT, 2'h1};
    // Ones go into reserved bits on purpose: they must come back as zero.
    foreach (bufW[i]) bufW[i] = 8'hFF;
    wr(8'h00, NUM_PROG);
    rd(8'h00, NUM_PROG);
    cmpAll();
    bufW = '{8'h12, 8'h50, 8'h40, 8'h6D, 8'h5E, 8'h0B, 8'hC8, 8'hA5, 8'h2A, 8'h07, 8'h3C};
    wr(8'h00, NUM_PROG);
    rd(8'h00, NUM_PROG);
    cmpAll();
    chk("divider", 16'h1250, {1'b0, intDivider});
    chk("fields", {bufW[4][6:0], bufW[5][3:0], bufW[6][7:3]}, {overloadThresholdField,
      pumpCurrentSelect, filterBandSelect, rfPowerDown, ifGainStagePowerDown, rfInputSelect,
      mixerPowerDown, ifSectionPowerDown, detectorPowerDown, synthPowerDown});
    chk("others", {1'b0, bufW[2][6:0], bufW[3]}, {1'b0, referenceDivider, oscBandSelect});
    chk("filter", {1'b0, bufW[8][7], bufW[8][5:0], 4'h0, bufW[9][3:0]},
      {1'b0, filterTableLoad, parallelCapSelect, 4'h0, filterRomAddress});
    $display("test registers done");
    bufW[0] = 8'hAA;
    bufW[1] = 8'hAA;
    wr(8'h0B, 2);
    rd(8'h0B, 2);
    // The readback still holds entry 0, loaded when all ones went in while the address was 0.
    chk("rom", {8'h0, ROM_TABLE[7:0]}, {8'h0, bufR[0]});
    chk("status", 16'h00D0, {8'h0, bufR[1]});
    bufW[0] = 8'h80;
    wr(8'h08, 1);
    lockIndicator = 3'h2;
    rd(8'h0B, 2);
    chk("rom", {8'h0, ROM_TABLE[56 +: 8]}, {8'h0, bufR[0]});
    chk("readback", {8'h0, ROM_TABLE[56 +: 8]}, {8'h0, romReadbackBits});
    chk("status", 16'h0020, {8'h0, bufR[1]});
    $display("test read-only done");
    for (int k = 0; k < 4; k++) begin
      {addrSelectPinB, addrSelectPinA} = k[1:0];
      devAddr = {ADDR_UPPER_DEFAULT, k[1:0]};
      bufW[0] = {6'h0, k[1:0]};
      wr(8'h07, 1);
      chk("ack", 16'h0000, {15'h0, ackA});
      devAddr = {ADDR_UPPER_DEFAULT, k[1:0] ^ 2'h1};
      bufW[0] = 8'h33;
      wr(8'h07, 1);
      chk("nack", 16'h0001, {15'h0, ackA});
      chk("series", {14'h0, k[1:0]}, {8'h0, seriesCapSelect});
    end
    $display("test address done");
    close_out();
  end
endmodule
`default_nettype wire
